// ---- src/pager_cfg_pkg.sv ----
/*
 pager_cfg_pkg: constants shared by the paging decoder start-up loader.
 Assumes the configuration store is read one 8-byte row per request.
*/
package pager_cfg_pkg;
    localparam int LOAD_CYCLES = 8;
    localparam int ID_SLOTS = 6;
    localparam int ROW_BYTES = 8;
    localparam logic [2:0] ROW_SPF = 3'h0;
    localparam logic [2:0] ROW_ID_B1 = 3'h2;
    localparam logic [2:0] ROW_ID_B2 = 3'h3;
    localparam logic [2:0] ROW_ID_B3 = 3'h4;
    // programmed function byte fields
    localparam int SPF0_ALT_PROTOCOL = 0;
    localparam int SPF0_CONT_DECODE = 6;
    localparam int SPF1_SYNTH_EN = 6;
    localparam int SPF1_VCONV_EN = 7;
    localparam int SPF2_REF_LSB = 2;
    localparam int SPF2_SIGNAL_TEST = 4;
    localparam int SPF3_INT_HIGH = 6;
    // identifier byte 3 fields
    localparam int B3_CW_HI = 7;
    localparam int B3_FR_MSB = 5;
    localparam int B3_FR_LSB = 3;
    localparam int B3_TYPE_HI = 2;
    localparam int B3_ENABLE = 1;
    localparam int B3_TYPE_LO = 0;
    localparam int STD_SYNC_ID = 7;
    localparam logic [9:0] BCH_POLY = 10'h369;
    localparam logic [1:0] SYNTH_LATCHES = 2'h2;
    // register port map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_SPF = 8'h04;
    localparam logic [7:0] REG_ID_ACTIVE = 8'h08;
    localparam logic [7:0] REG_CONTROL = 8'h0c;
    localparam int CTRL_RX_HOLD = 0;
    localparam int PIN_RST = 0;
    localparam int PIN_PON = 1;
    localparam int PIN_OSC = 2;
    typedef enum logic [1:0] {
        id_prog_sync = 2'b00,
        id_cont_decode = 2'b01,
        id_user_address = 2'b10,
        id_batch_zero = 2'b11
    } id_kind_type;
    typedef enum logic [1:0] {
        ref_32768 = 2'b00,
        ref_50hz = 2'b01,
        ref_2hz = 2'b10,
        ref_sixtieth = 2'b11
    } ref_sel_type;
    typedef enum logic [1:0] {
        st_reset = 2'b00,
        st_load = 2'b01,
        st_run = 2'b10
    } load_state_type;
endpackage

// ---- src/pager_reset_config_loader.sv ----
/*
 pager_reset_config_loader: reset handling, configuration load after reset,
 identifier decode and output gating of a paging decoder.
 Assumes a row-wide configuration store answering one cycle after the row
 address, timebase square waves and decoder requests on mclk, and the reset,
 power-on and oscillator-ready levels arriving asynchronously from pins.
*/
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module pager_reset_config_loader
    import pager_cfg_pkg::*;
#(
    parameter int VCONV_DIV = 16,
    parameter logic [1:0] PROGRAMMABLE_SYNC_WORD_FUNC_BITS = 2'b00
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic rst_pin,
    input wire logic power_on_control,
    input wire logic osc_ready,
    output logic [2:0] eeprom_row_addr,
    input wire logic [63:0] eeprom_row_data,
    input wire logic synth_latch_enable,
    input wire logic ref_32768_in,
    input wire logic ref_50hz_in,
    input wire logic ref_2hz_in,
    input wire logic ref_sixtieth_in,
    input wire logic noise_filter_in,
    input wire logic bit_clock_in,
    input wire logic int_request,
    input wire logic indicator_req,
    input wire logic vibrator_req,
    input wire logic alerter_high_req,
    input wire logic alerter_low_req,
    input wire logic sda_low_req,
    input wire logic scl_low_req,
    output logic ref_out,
    output logic int_out,
    output logic clock_run,
    output logic on_status,
    output logic receiver_enable_out,
    output logic receiver_oscillator_enable_out,
    output logic indicator_output,
    output logic vibrator_output,
    output logic alerter_high_output,
    output logic alerter_low_output,
    output logic alerter_low_oe,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    output logic vconv_enable,
    output logic vconv_clk,
    output logic [5:0][17:0] id_codeword_bits,
    output logic [5:0][2:0] id_frame_number,
    output logic [5:0][1:0] id_kind,
    output logic [5:0] id_active,
    output logic [5:0][31:0] programmable_sync_word_codeword,
    output logic std_sync_active,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata
);

    function automatic logic [31:0] make_programmable_sync_word(input logic [17:0] pattern);
        logic [20:0] d;
        logic [9:0] r;
        logic fb;
        d = {1'b0, pattern, PROGRAMMABLE_SYNC_WORD_FUNC_BITS};
        r = 10'h000;
        for (int i = 20; i >= 0; i--) begin
            fb = d[i] ^ r[9];
            r = {r[8:0], 1'b0};
            if (fb) begin
                r = r ^ BCH_POLY;
            end
        end
        return {d, r, ^{d, r}};
    endfunction

    function automatic logic slot_enable(input int slot, input logic [7:0] b3,
                                         input logic alt_en, input logic cdd_en);
        logic [1:0] kind;
        kind = {b3[B3_TYPE_HI], b3[B3_TYPE_LO]};
        if (!b3[B3_ENABLE]) begin
            return 1'b0;
        end
        if (slot < 2 && !b3[B3_TYPE_HI]) begin
            return 1'b0;
        end
        if (kind == id_batch_zero && !alt_en) begin
            return 1'b0;
        end
        if (kind == id_cont_decode && !cdd_en) begin
            return 1'b0;
        end
        return 1'b1;
    endfunction

    logic [2:0] pin_raw;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_lvl;
    logic in_reset;
    logic pon;
    logic osc_ok;
    load_state_type state;
    logic [2:0] load_cnt;
    logic [2:0] row_idx;
    logic [3:0][7:0] programmed_function_bytes;
    logic [5:0][7:0] id_b1;
    logic [5:0][7:0] id_b2;
    logic [5:0][7:0] id_b3;
    logic running;
    logic latch_prev;
    logic [1:0] latch_cnt;
    logic synth_ready;
    logic ctrl_hold;
    logic [15:0] vconv_cnt;
    logic alt_en;
    logic cdd_en;
    logic signal_test;
    logic int_high;
    logic ref_pick;

    // reset, power-on and oscillator-ready come from pins: three flops, level on agreement
    assign pin_raw = {osc_ready, power_on_control, rst_pin};

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_s1 <= 3'h1;
            pin_s2 <= 3'h1;
            pin_s3 <= 3'h1;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    for (genvar p = 0; p < 3; p++) begin : g_pin
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                pin_lvl[p] <= (p == PIN_RST);
            end else if (pin_s2[p] == pin_s3[p]) begin
                pin_lvl[p] <= pin_s3[p];
            end
        end
    end

    assign in_reset = pin_lvl[PIN_RST];
    assign pon = pin_lvl[PIN_PON];
    assign osc_ok = pin_lvl[PIN_OSC];
    assign running = (state == st_run);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= st_reset;
        end else if (in_reset) begin
            state <= st_reset;
        end else begin
            unique case (state)
                st_reset: begin
                    state <= st_load;
                end
                st_load: begin
                    if (load_cnt == 3'(LOAD_CYCLES - 1)) begin
                        state <= st_run;
                    end
                end
                st_run: begin
                    state <= st_run;
                end
                default: begin
                    state <= st_reset;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            load_cnt <= 3'h0;
        end else if (state == st_load && !in_reset) begin
            load_cnt <= load_cnt + 3'h1;
        end else begin
            load_cnt <= 3'h0;
        end
    end

    assign eeprom_row_addr = (state == st_load) ? load_cnt : 3'h0;
    assign row_idx = load_cnt - 3'h1;

    // store answers one cycle late, so row n lands while the counter shows n+1
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            programmed_function_bytes <= '0;
            id_b1 <= '0;
            id_b2 <= '0;
            id_b3 <= '0;
        end else if (in_reset) begin
            programmed_function_bytes <= '0;
            id_b1 <= '0;
            id_b2 <= '0;
            id_b3 <= '0;
        end else if (state == st_load && load_cnt != 3'h0) begin
            for (int i = 0; i < ID_SLOTS; i++) begin
                if (row_idx == ROW_SPF && i < 4) begin
                    programmed_function_bytes[i[1:0]] <= eeprom_row_data[8*i +: 8];
                end
                if (row_idx == ROW_ID_B1) begin
                    id_b1[i] <= eeprom_row_data[8*i +: 8];
                end
                if (row_idx == ROW_ID_B2) begin
                    id_b2[i] <= eeprom_row_data[8*i +: 8];
                end
                if (row_idx == ROW_ID_B3) begin
                    id_b3[i] <= eeprom_row_data[8*i +: 8];
                end
            end
        end
    end

    // until the load ends every setting behaves as if programmed zero
    assign alt_en = running & programmed_function_bytes[0][SPF0_ALT_PROTOCOL];
    assign cdd_en = running & programmed_function_bytes[0][SPF0_CONT_DECODE];
    assign signal_test = running & programmed_function_bytes[2][SPF2_SIGNAL_TEST];
    assign int_high = running & programmed_function_bytes[3][SPF3_INT_HIGH];
    assign synth_ready = !(running & programmed_function_bytes[1][SPF1_SYNTH_EN]) || latch_cnt == SYNTH_LATCHES;

    always_comb begin
        unique case (ref_sel_type'(running ? programmed_function_bytes[2][SPF2_REF_LSB +: 2] : 2'b00))
            ref_32768: ref_pick = ref_32768_in;
            ref_50hz: ref_pick = ref_50hz_in;
            ref_2hz: ref_pick = ref_2hz_in;
            ref_sixtieth: ref_pick = ref_sixtieth_in;
        endcase
    end

    // a latch pulse completes on its falling edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            latch_prev <= 1'b0;
            latch_cnt <= 2'h0;
        end else if (in_reset) begin
            latch_prev <= 1'b0;
            latch_cnt <= 2'h0;
        end else begin
            latch_prev <= synth_latch_enable;
            if (latch_prev && !synth_latch_enable && latch_cnt != SYNTH_LATCHES) begin
                latch_cnt <= latch_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_hold <= 1'b0;
        end else if (in_reset) begin
            ctrl_hold <= 1'b0;
        end else if (reg_write && reg_addr == REG_CONTROL) begin
            ctrl_hold <= reg_wdata[CTRL_RX_HOLD];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            vconv_cnt <= 16'h0000;
            vconv_clk <= 1'b0;
        end else if (in_reset || !vconv_enable) begin
            vconv_cnt <= 16'h0000;
            vconv_clk <= 1'b0;
        end else if (vconv_cnt == 16'(VCONV_DIV - 1)) begin
            vconv_cnt <= 16'h0000;
            vconv_clk <= !vconv_clk;
        end else begin
            vconv_cnt <= vconv_cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ref_out <= 1'b0;
            int_out <= 1'b0;
            clock_run <= 1'b0;
            on_status <= 1'b0;
            receiver_enable_out <= 1'b0;
            receiver_oscillator_enable_out <= 1'b0;
            vconv_enable <= 1'b0;
        end else if (in_reset) begin
            ref_out <= ref_32768_in;
            int_out <= 1'b0;
            clock_run <= 1'b0;
            on_status <= 1'b0;
            receiver_enable_out <= 1'b0;
            receiver_oscillator_enable_out <= 1'b0;
            vconv_enable <= 1'b0;
        end else begin
            ref_out <= signal_test ? noise_filter_in : ref_pick;
            // idle level is high for low-active polarity: start-up shows as a rise
            if (!osc_ok) begin
                int_out <= 1'b0;
            end else if (signal_test) begin
                int_out <= bit_clock_in;
            end else begin
                int_out <= int_high ? int_request : !int_request;
            end
            clock_run <= 1'b1;
            on_status <= running & pon;
            receiver_enable_out <= running & pon & synth_ready & !ctrl_hold;
            receiver_oscillator_enable_out <= running & pon & synth_ready & !ctrl_hold;
            vconv_enable <= running & programmed_function_bytes[1][SPF1_VCONV_EN];
        end
    end

    // open-drain lines only ever pull low
    assign alerter_low_output = 1'b0;
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            indicator_output <= 1'b0;
            vibrator_output <= 1'b0;
            alerter_high_output <= 1'b0;
            alerter_low_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
        end else if (in_reset) begin
            indicator_output <= 1'b0;
            vibrator_output <= 1'b0;
            alerter_high_output <= 1'b0;
            alerter_low_oe <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            indicator_output <= indicator_req;
            vibrator_output <= vibrator_req;
            alerter_high_output <= alerter_high_req;
            alerter_low_oe <= alerter_low_req;
            sda_oe <= sda_low_req;
            scl_oe <= scl_low_req;
        end
    end

    for (genvar s = 0; s < ID_SLOTS; s++) begin : g_slot
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                id_codeword_bits[s] <= 18'h00000;
                id_frame_number[s] <= 3'h0;
                id_kind[s] <= 2'h0;
                id_active[s] <= 1'b0;
                programmable_sync_word_codeword[s] <= 32'h00000000;
            end else begin
                id_codeword_bits[s] <= {id_b1[s], id_b2[s], id_b3[s][B3_CW_HI -: 2]};
                id_frame_number[s] <= id_b3[s][B3_FR_MSB:B3_FR_LSB];
                id_kind[s] <= {id_b3[s][B3_TYPE_HI], id_b3[s][B3_TYPE_LO]};
                id_active[s] <= running & slot_enable(s, id_b3[s], alt_en, cdd_en);
                // bit 31 is the address flag and stays zero for a sync word
                programmable_sync_word_codeword[s] <= make_programmable_sync_word({id_b1[s], id_b2[s], id_b3[s][B3_CW_HI -: 2]});
            end
        end
    end

    // the standard sync word has no enable bit to clear
    assign std_sync_active = running;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            unique case (reg_addr)
                REG_STATUS: reg_rdata <= {25'h0000000, latch_cnt, receiver_enable_out,
                                          osc_ok, on_status, running, in_reset};
                REG_SPF: reg_rdata <= programmed_function_bytes;
                REG_ID_ACTIVE: reg_rdata <= {26'h0000000, id_active};
                REG_CONTROL: reg_rdata <= {31'h00000000, ctrl_hold};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence load_phase;
        (state == st_load)[*8];
    endsequence

    sequence load_start;
        (state == st_reset) && !in_reset;
    endsequence

    load_length_a: assert property (load_start |=> load_phase ##1 running)
        else $error("load did not last eight cycles");
    reset_alerts_a: assert property (in_reset |=> !indicator_output && !vibrator_output
        && !alerter_high_output && !alerter_low_oe && !sda_oe && !scl_oe)
        else $error("alert or bus line active in reset");
    reset_int_a: assert property (in_reset |=> !int_out && !on_status && !ctrl_hold)
        else $error("interrupt or state not cleared in reset");
    reset_ref_a: assert property (in_reset |=> ref_out == $past(ref_32768_in))
        else $error("reference not 32768 Hz in reset");
    reset_clocks_a: assert property (in_reset |=> !clock_run && !vconv_clk)
        else $error("clocks running in reset");
    rx_gate_a: assert property ($rose(receiver_enable_out) |->
        $past(running && pon && synth_ready))
        else $error("receiver enabled before synth load");
    on_start_a: assert property (load_start ##1 load_phase ##1 (running && pon && !in_reset)
        |=> on_status)
        else $error("on status late after load");
    slot_disable_a: assert property (!id_b3[0][B3_TYPE_HI] || !id_b3[1][B3_TYPE_HI]
        |=> !(id_active[0] && !$past(id_b3[0][B3_TYPE_HI]))
        && !(id_active[1] && !$past(id_b3[1][B3_TYPE_HI])))
        else $error("slot one or two active without user type");
    enable_bit_a: assert property (id_active[5] |-> $past(id_b3[5][B3_ENABLE]))
        else $error("identifier active with enable clear");
    stable_cfg_a: assert property (running && $past(running) |-> $stable(programmed_function_bytes)
        && $stable(id_b3))
        else $error("configuration changed after load");
    settings_zero_a: assert property (!running |=> !vconv_enable)
        else $error("converter enabled before load end");

endmodule

// ---- tb/config_store_model.sv ----
/*
 config_store_model: behavioural row-wide configuration store for the loader.
 Assumes the bench fills the rows before releasing reset; answers one cycle
 after the row address, like the real store.
*/
`timescale 1ns/1ps
module config_store_model (
    input wire logic mclk,
    input wire logic [2:0] row_addr,
    input wire logic [63:0] rows [8],
    output logic [63:0] row_data
);
    // contents are programmed by the bench before each reset is released
    always_ff @(posedge mclk) begin
        row_data <= rows[row_addr];
    end
endmodule

// ---- tb/testbench.sv ----
/*
 testbench: reset forcing, post-reset load, identifier decode and gating checks.
 Assumes a 50 MHz mclk, the store model beside the design, VCONV_DIV of 2.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module testbench;
    import pager_cfg_pkg::*;
    logic mclk = 0, resetn = 0, rst_pin = 1, power_on_control = 1, osc_ready = 0;
    logic [2:0] eeprom_row_addr;
    logic [63:0] eeprom_row_data, rows [8], ex [8];
    logic synth_latch_enable = 0, ref_32768_in = 0, ref_50hz_in = 0, ref_2hz_in = 0;
    logic ref_sixtieth_in = 0, noise_filter_in = 0, bit_clock_in = 0, int_request = 0;
    logic indicator_req = 1, vibrator_req = 1, alerter_high_req = 1, alerter_low_req = 1;
    logic sda_low_req = 1, scl_low_req = 1, reg_write = 0, reg_read = 0, pend = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, e1;
    logic ref_out, int_out, clock_run, on_status, receiver_enable_out;
    logic receiver_oscillator_enable_out, indicator_output, vibrator_output;
    logic alerter_high_output, alerter_low_output, alerter_low_oe, sda_out, sda_oe;
    logic scl_out, scl_oe, vconv_enable, vconv_clk, std_sync_active;
    logic [5:0][17:0] id_codeword_bits;
    logic [5:0][2:0] id_frame_number;
    logic [5:0][1:0] id_kind;
    logic [5:0] id_active, act;
    logic [5:0][31:0] programmable_sync_word_codeword;
    logic [31:0] exp_q [$];
    int mismatches = 0, comparisons = 0, seed = 73;

    always #10 mclk = ~mclk;

    pager_reset_config_loader #(.VCONV_DIV(2)) dut (.*);
    config_store_model store (.mclk(mclk), .row_addr(eeprom_row_addr), .rows(rows),
        .row_data(eeprom_row_data));

    // read data stands only in the cycle after the strobe
    always @(negedge mclk) begin
        if (pend) begin
            e1 = exp_q.pop_front();
            `CHK("reg_rdata", e1, reg_rdata)
        end
        pend = reg_read;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge mclk);
        reg_read <= 1'b0;
    endtask

    // sel 0..5: 32768 Hz, 50 Hz, noise filter to ref_out; bit clock to int_out;
    // 2 Hz, sixtieth to ref_out
    task automatic follow(input int sel);
        logic prev;
        prev = 1'b0;
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk);
            {ref_32768_in, ref_50hz_in, noise_filter_in, bit_clock_in, ref_2hz_in,
                ref_sixtieth_in} <= 6'($random(seed));
            @(negedge mclk);
            if (i > 0) `CHK("follow", prev, (sel == 3) ? int_out : ref_out)
            prev = (sel == 0) ? ref_32768_in : (sel == 1) ? ref_50hz_in :
                (sel == 2) ? noise_filter_in : (sel == 3) ? bit_clock_in :
                (sel == 4) ? ref_2hz_in : ref_sixtieth_in;
        end
    endtask

    task automatic check_ids();
        logic [7:0] b3;
        logic en;
        for (int s = 0; s < ID_SLOTS; s++) begin
            b3 = ex[4][8*s+:8];
            en = b3[1] & (s > 1 | b3[2]);
            if ({b3[2], b3[0]} == 2'b11) en &= ex[0][0];
            if ({b3[2], b3[0]} == 2'b01) en &= ex[0][6];
            act[s] = en;
            `CHK("codeword", {ex[2][8*s+:8], ex[3][8*s+:8], b3[7:6]}, id_codeword_bits[s])
            `CHK("frame", b3[5:3], id_frame_number[s])
            `CHK("kind", {b3[2], b3[0]}, id_kind[s])
            `CHK("active", en, id_active[s])
            `CHK("sync", {1'b0, ex[2][8*s+:8], ex[3][8*s+:8], b3[7:6], 2'b00},
                programmable_sync_word_codeword[s][31:11])
            `CHK("parity", 1'b0, ^programmable_sync_word_codeword[s])
        end
    endtask

    task automatic do_reset(input logic [63:0] programmed_function_bytes);
        logic [2:0] hist [8];
        int n;
        rows[0] = programmed_function_bytes;
        rows[2] = {$random(seed), $random(seed)};
        rows[3] = {$random(seed), $random(seed)};
        // slot byte 3 type bits cover every kind, enabled and disabled
        rows[4] = 64'h0000_0604_0302_0702 | ({$random(seed), $random(seed)} & 64'hf8f8_f8f8_f8f8);
        ex = rows;
        @(posedge mclk);
        rst_pin <= 1'b1;
        repeat (2500) @(posedge mclk);
        @(negedge mclk);
        `CHK("on", 1'b0, on_status)
        `CHK("int", 1'b0, int_out)
        `CHK("rx", 2'b00, {receiver_enable_out, receiver_oscillator_enable_out})
        `CHK("alerts", 3'h0, {indicator_output, vibrator_output, alerter_high_output})
        `CHK("oe", 3'h0, {alerter_low_oe, sda_oe, scl_oe})
        `CHK("clocks", 3'h0, {clock_run, vconv_clk, vconv_enable})
        follow(0);
        @(posedge mclk);
        rst_pin <= 1'b0;
        n = 0;
        while (std_sync_active !== 1'b1 && n < 40) begin
            @(negedge mclk);
            hist[n % 8] = eeprom_row_addr;
            n++;
        end
        `CHK("load_time", 1'b1, n <= 16)
        // the last record is the first running cycle and shows address 0, standing for row 0; rows 1..7 end one before it
        for (int k = 0; k < 8; k++) `CHK("row", 3'(k), hist[(n + 7 + k) % 8])
        repeat (3) @(negedge mclk);
        check_ids();
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        int n;
        logic v;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        // alternate protocol on, converter on, 50 Hz reference, interrupt active low
        do_reset(64'h0000_0000_0004_8001);
        `CHK("on", 1'b1, on_status)
        `CHK("rx", 2'b11, {receiver_enable_out, receiver_oscillator_enable_out})
        `CHK("vconv", 1'b1, vconv_enable)
        `CHK("std_sync", 1'b1, std_sync_active)
        `CHK("run", 1'b1, clock_run)
        `CHK("od_data", 3'h0, {alerter_low_output, sda_out, scl_out})
        `CHK("alerts", 6'h3f, {indicator_output, vibrator_output, alerter_high_output,
            alerter_low_oe, sda_oe, scl_oe})
        `CHK("int_wait", 1'b0, int_out)
        follow(1);
        v = vconv_clk;
        n = 0;
        repeat (16) begin
            @(negedge mclk);
            n += int'(vconv_clk !== v);
            v = vconv_clk;
        end
        `CHK("vconv_clk", 8, n)
        @(posedge mclk);
        osc_ready <= 1'b1;
        n = 0;
        while (int_out !== 1'b1 && n < 10) begin
            @(negedge mclk);
            n++;
        end
        `CHK("int_rise", 1'b1, int_out)
        @(posedge mclk);
        int_request <= 1'b1;
        repeat (5) @(negedge mclk);
        `CHK("int_low_active", 1'b0, int_out)
        @(posedge mclk);
        int_request <= 1'b0;
        // store changes after loading must not reach the decoded settings
        rows[0] = ~rows[0];
        rows[2] = ~rows[2];
        rows[4] = ~rows[4];
        repeat (10) @(negedge mclk);
        check_ids();
        rd(REG_STATUS, 32'h0000_001e);
        rd(REG_SPF, 32'h0004_8001);
        rd(REG_ID_ACTIVE, {26'h0, act});
        rd(8'h10, 32'h0);
        wr(REG_SPF, 32'hffff_ffff);
        rd(REG_SPF, 32'h0004_8001);
        wr(REG_CONTROL, 32'h1);
        rd(REG_CONTROL, 32'h1);
        // continuous decoding on, synthesizer on, signal test, interrupt active high
        do_reset(64'h0000_0000_4010_4040);
        rd(REG_CONTROL, 32'h0);
        @(negedge mclk);
        `CHK("rx_gated", 2'b00, {receiver_enable_out, receiver_oscillator_enable_out})
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            synth_latch_enable <= 1'b1;
            repeat (3) @(posedge mclk);
            synth_latch_enable <= 1'b0;
            repeat (4) @(negedge mclk);
            `CHK("rx_latch", {2{i[0]}}, {receiver_enable_out, receiver_oscillator_enable_out})
        end
        follow(2);
        follow(3);
        // remaining reference choices: 2 Hz, then one sixtieth of a hertz
        do_reset(64'h0000_0000_0008_0000);
        follow(4);
        do_reset(64'h0000_0000_000c_0000);
        follow(5);
        report_and_stop();
    end
endmodule
